// ===== hw/csf_supervisor.sv
// charger supervisor: state machine, status flags, faults, sync, drive gating
// assumes comparator outputs as pins, Avalon-MM master on CLOCK
//
// Functional notes
// - off shows code 11; precharge, CC, absorption show code 10
// - float shows code 00; latched fault or temperature suspend shows 01
// - temperature suspend is not latched and clears itself
// - latched fault holds, charging stops until power is recycled
// - power-up checks of pins and reference; any failure latches fault
// - reference window, gate drive or feedback low latches fault in any charging state or in suspend, not in off
// - precharge timer count beyond precharge timeout latches faulty battery
// - battery temperature out of range suspends charge and pauses timer
// - temperature back in range resumes previous state and timer
// - unconnected frequency pin gives internal 350kHz switching clock
// - external sync declared present after 112 internal-cycle check
// - valid sync: blank switching two periods, then switch on external
// - sync lost: blank switching ten periods, then switch on internal
// - peak overcurrent ends the high-side pulse, nothing latched
// - shut down above 160C, restart after 10C cooling
// - timer counts in precharge and absorption only, clears in check and off and on entering absorption from CC, holds elsewhere
// - leaving absorption for float resets timer and pulls flag b
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module csf_supervisor
#(
  parameter int TMR_FCHG = csf_pkg::FCHG_TICKS,
  parameter int SW_PERIOD = csf_pkg::SW_PERIOD_CYC
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ,
  input wire logic CHARGE_ENABLE,
  input wire logic FREQ_SET_SHORT,
  input wire logic GATE_SHORT,
  input wire logic TIMER_PIN_OPEN,
  input wire logic TIMER_PIN_SHORT,
  input wire logic REF_SHORT,
  input wire logic REF_OUT_OF_WINDOW,
  input wire logic GATE_DRIVE_LOW,
  input wire logic FEEDBACK_LOW,
  input wire logic TEMP_OUT_OF_RANGE,
  input wire logic DEEP_DISCHARGE_OK,
  input wire logic CV_REACHED,
  input wire logic CURRENT_TAPERED,
  input wire logic PEAK_OVERCURRENT,
  input wire logic JUNCTION_HOT,
  input wire logic JUNCTION_COOLED,
  input wire logic CHARGE_TIMER_TICK,
  input wire logic FREQ_SET_SYNC_PIN,
  output logic STATUS_FLAG_A_O,
  output logic STATUS_FLAG_A_OE,
  output logic STATUS_FLAG_B_O,
  output logic STATUS_FLAG_B_OE,
  output logic HIGH_SIDE_DRIVE,
  output logic EXT_CLOCK_ACTIVE
);
  import csf_pkg::*;

  localparam int NPIN = 18;
  localparam logic [TMR_W-1:0] FCHG_LIM = TMR_W'(TMR_FCHG);
  localparam logic [TMR_W-1:0] PCHG_LIM = TMR_W'(TMR_FCHG / PCHG_DIV);
  localparam int SWC_W = $clog2(2 * SW_PERIOD + 2);

  // two-flop synchronisers for every pin input
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_s;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      pin_meta <= '0;
      pin_s <= '0;
    end
    else
    begin
      pin_meta <= {CHARGE_ENABLE, FREQ_SET_SHORT, GATE_SHORT, TIMER_PIN_OPEN,
                   TIMER_PIN_SHORT, REF_SHORT, REF_OUT_OF_WINDOW, GATE_DRIVE_LOW,
                   FEEDBACK_LOW, TEMP_OUT_OF_RANGE, DEEP_DISCHARGE_OK, CV_REACHED,
                   CURRENT_TAPERED, PEAK_OVERCURRENT, JUNCTION_HOT, JUNCTION_COOLED,
                   CHARGE_TIMER_TICK, FREQ_SET_SYNC_PIN};
      pin_s <= pin_meta;
    end
  end

  wire en_s = pin_s[17];
  wire check_fail = |pin_s[16:12];
  wire run_fault = |pin_s[11:9];
  wire temp_bad = pin_s[8];
  wire deep_discharge_sense_ok = pin_s[7];
  wire cv_ok = pin_s[6];
  wire tapered = pin_s[5];
  wire overcur = pin_s[4];
  wire tj_hot = pin_s[3];
  wire tj_cool = pin_s[2];
  wire tick_s = pin_s[1];
  wire sync_s = pin_s[0];

  csf_state_t state;
  csf_state_t next_state;
  csf_state_t prev;
  csf_state_t next_prev;
  logic [1:0] chk_cnt;
  logic [31:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [TMR_W-1:0] timer;
  logic tick_d;
  logic tsd;
  logic [SWC_W-1:0] sw_cnt;
  logic [SWC_W-1:0] on_cnt;
  logic [3:0] blank_cnt;
  logic sel_ext;
  logic present_d;
  logic sync_present;
  logic ext_edge;
  logic [1:0] flag_code;

  wire tmr_en = ctrl[CTRL_TMR_EN_BIT];
  wire [7:0] duty = ctrl[CTRL_DUTY_LSB +: 8];
  wire charge_on = en_s & ~tsd;
  wire charging = (state == ST_PRE) || (state == ST_CC) || (state == ST_ABS) || (state == ST_FLOAT);
  wire pre_timeout = tmr_en && (timer > PCHG_LIM);
  wire abs_timeout = tmr_en && (timer >= FCHG_LIM);
  wire tmr_edge = tick_s & ~tick_d;
  wire tmr_counting = tmr_en && ((state == ST_PRE) || (state == ST_ABS));

  // charger state machine
  always_comb
  begin
    next_state = state;
    next_prev = prev;
    if (charging && run_fault)
      next_state = ST_FAULT;
    else if (charging && !charge_on)
      next_state = ST_OFF;
    else if (charging && temp_bad)
    begin
      next_state = ST_SUSP;
      next_prev = state;
    end
    else
    begin
      case (state)
        ST_CHECK:
          if (chk_cnt == 2'(CHECK_WAIT))
            next_state = check_fail ? ST_FAULT : ST_OFF;
        ST_OFF:
          if (charge_on)
            next_state = ST_PRE;
        ST_PRE:
          if (pre_timeout)
            next_state = ST_FAULT;
          else if (deep_discharge_sense_ok)
            next_state = ST_CC;
        ST_CC:
          if (cv_ok)
            next_state = ST_ABS;
        ST_ABS:
          if (tapered || abs_timeout)
            next_state = ST_FLOAT;
        ST_FLOAT:
          next_state = ST_FLOAT;
        ST_SUSP:
          if (run_fault)
            next_state = ST_FAULT;
          else if (!charge_on)
            next_state = ST_OFF;
          else if (!temp_bad)
            next_state = prev;
        ST_FAULT:
          next_state = ST_FAULT;
        default:
          next_state = ST_CHECK;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state <= ST_CHECK;
      prev <= ST_PRE;
      chk_cnt <= 2'h0;
    end
    else
    begin
      state <= next_state;
      prev <= next_prev;
      if (state == ST_CHECK)
        chk_cnt <= chk_cnt + 2'h1;
    end
  end

  // charge timer; suspend leaves the count untouched so it resumes
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      timer <= '0;
      tick_d <= 1'b0;
    end
    else
    begin
      tick_d <= tick_s;
      if (next_state == ST_FLOAT && state == ST_ABS)
        timer <= '0;
      else if (state == ST_OFF || state == ST_CHECK)
        timer <= '0;
      else if (state == ST_CC && next_state == ST_ABS)
        timer <= '0;
      else if (tmr_counting && tmr_edge && timer != FCHG_LIM)
        timer <= timer + TMR_W'(1);
    end
  end

  // thermal shutdown with hysteresis from two comparators
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      tsd <= 1'b0;
    else if (tj_hot)
      tsd <= 1'b1;
    else if (tj_cool)
      tsd <= 1'b0;
  end

  // internal switching oscillator, default frequency
  wire int_tick = sw_cnt == SWC_W'(SW_PERIOD - 1);
  wire period_tick = sel_ext ? ext_edge : int_tick;
  wire present_rise = sync_present & ~present_d;
  wire present_fall = ~sync_present & present_d;

  csf_sync_det #(.PERIOD(SW_PERIOD), .CHECKS(SYNC_CHECK_PERIODS)) u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .sync_in(sync_s),
    .int_tick(int_tick),
    .present(sync_present),
    .ext_edge(ext_edge)
  );

  // blanking counts internal periods; the external clock may be gone
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      sw_cnt <= '0;
      blank_cnt <= 4'h0;
      sel_ext <= 1'b0;
      present_d <= 1'b0;
    end
    else
    begin
      // restart the period on lock or loss so blanking lasts whole periods
      sw_cnt <= (int_tick || present_rise || present_fall) ? '0 : sw_cnt + SWC_W'(1);
      present_d <= sync_present;
      if (present_rise)
      begin
        blank_cnt <= 4'(BLANK_LOCK_PERIODS);
        sel_ext <= 1'b1;
      end
      else if (present_fall)
      begin
        blank_cnt <= 4'(BLANK_LOSS_PERIODS);
        sel_ext <= 1'b0;
      end
      else if (int_tick && blank_cnt != 4'h0)
        blank_cnt <= blank_cnt - 4'h1;
    end
  end

  // high-side pulse: duty/256 of the nominal period, cut by overcurrent
  wire [SWC_W+7:0] on_prod = (SWC_W + 8)'(SW_PERIOD) * (SWC_W + 8)'(duty);
  wire [SWC_W-1:0] on_lim = on_prod[SWC_W+7:8];
  wire drive_ok = charging && !tsd && blank_cnt == 4'h0 && next_state == state;
  wire next_hs = period_tick ? (drive_ok && on_lim != '0)
                             : (HIGH_SIDE_DRIVE && drive_ok && !overcur && on_cnt < on_lim);

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      on_cnt <= '0;
      HIGH_SIDE_DRIVE <= 1'b0;
      EXT_CLOCK_ACTIVE <= 1'b0;
    end
    else
    begin
      on_cnt <= period_tick ? SWC_W'(1) : (on_cnt == on_lim ? on_cnt : on_cnt + SWC_W'(1));
      HIGH_SIDE_DRIVE <= next_hs;
      EXT_CLOCK_ACTIVE <= sel_ext && blank_cnt == 4'h0;
    end
  end

  // status code from state, latched only on internal oscillator ticks to avoid glitches
  wire [1:0] state_code = (state == ST_FLOAT) ? CODE_FLOAT :
                          (state == ST_FAULT || state == ST_SUSP) ? CODE_FAULT :
                          (state == ST_PRE || state == ST_CC || state == ST_ABS) ? CODE_CHARGING :
                          CODE_OFF;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      flag_code <= CODE_OFF;
      STATUS_FLAG_A_O <= 1'b0;
      STATUS_FLAG_B_O <= 1'b0;
      STATUS_FLAG_A_OE <= 1'b0;
      STATUS_FLAG_B_OE <= 1'b0;
    end
    else if (int_tick)
    begin
      flag_code <= state_code;
      STATUS_FLAG_A_OE <= ~state_code[0];
      STATUS_FLAG_B_OE <= ~state_code[1];
    end
  end

  // interrupt events
  wire [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_FAULT] = next_state == ST_FAULT && state != ST_FAULT;
  assign irq_event[IRQ_SUSP] = next_state == ST_SUSP && state != ST_SUSP;
  assign irq_event[IRQ_FLOAT] = next_state == ST_FLOAT && state != ST_FLOAT;
  assign irq_event[IRQ_LOCK] = present_rise;
  assign irq_event[IRQ_LOSS] = present_fall;
  assign irq_event[IRQ_TSD] = tj_hot && !tsd;

  // Avalon-MM slave: one wait cycle, access completes on the second edge
  wire req = AVS_READ | AVS_WRITE;
  wire done = req & ~AVS_WAITREQUEST;
  wire wr_ctrl = done && AVS_WRITE && AVS_ADDRESS == ADDR_CTRL;
  wire wr_stat = done && AVS_WRITE && AVS_ADDRESS == ADDR_IRQ_STAT;
  wire wr_mask = done && AVS_WRITE && AVS_ADDRESS == ADDR_IRQ_MASK;
  wire [IRQ_W-1:0] w1c = wr_stat ? AVS_WRITEDATA[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~w1c) | irq_event;
  wire [31:0] state_word = {16'h0000, 2'h0, flag_code, 1'b0, tsd, sel_ext, sync_present, state};
  wire [31:0] rd_mux = (AVS_ADDRESS == ADDR_CTRL) ? ctrl :
                       (AVS_ADDRESS == ADDR_STATE) ? state_word :
                       (AVS_ADDRESS == ADDR_IRQ_STAT) ? {26'h000_0000, irq_stat} :
                       (AVS_ADDRESS == ADDR_IRQ_MASK) ? {26'h000_0000, irq_mask} :
                       (AVS_ADDRESS == ADDR_TIMER) ? {10'h000, timer} :
                       32'h0000_0000;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
      ctrl <= CTRL_RESET;
      irq_stat <= '0;
      irq_mask <= IRQ_MASK_RESET;
      IRQ <= 1'b0;
    end
    else
    begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
      if (req && AVS_WAITREQUEST)
        AVS_READDATA <= rd_mux;
      if (wr_ctrl)
        ctrl <= AVS_WRITEDATA;
      if (wr_mask)
        irq_mask <= AVS_WRITEDATA[IRQ_W-1:0];
      // set wins over a simultaneous write-one-to-clear
      irq_stat <= next_irq_stat;
      IRQ <= |(next_irq_stat & (wr_mask ? AVS_WRITEDATA[IRQ_W-1:0] : irq_mask));
    end
  end

endmodule : csf_supervisor

// ===== hw/csf_pkg.sv
// constants shared by the charger supervisor and its sync-clock detector
// assumes a single 50 MHz system clock and a synchronous active-low reset
package csf_pkg;

  localparam int CLK_KHZ = 50_000;
  localparam int SW_FREQ_KHZ = 350;
  localparam int SW_PERIOD_CYC = CLK_KHZ / SW_FREQ_KHZ;
  localparam int SYNC_CHECK_PERIODS = 112;
  localparam int SYNC_TOL_PCT = 10;
  localparam int BLANK_LOCK_PERIODS = 2;
  localparam int BLANK_LOSS_PERIODS = 10;
  localparam int FCHG_TICKS = 2097151;
  localparam int PCHG_DIV = 8;
  localparam int TMR_W = 22;
  localparam int CHECK_WAIT = 3;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_TIMER = 8'h10;

  localparam int CTRL_TMR_EN_BIT = 0;
  localparam int CTRL_DUTY_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_8001;

  localparam int IRQ_FAULT = 0;
  localparam int IRQ_SUSP = 1;
  localparam int IRQ_FLOAT = 2;
  localparam int IRQ_LOCK = 3;
  localparam int IRQ_LOSS = 4;
  localparam int IRQ_TSD = 5;
  localparam int IRQ_W = 6;
  localparam logic [5:0] IRQ_MASK_RESET = 6'h00;

  localparam int STATE_SYNC_BIT = 8;
  localparam int STATE_EXT_BIT = 9;
  localparam int STATE_TSD_BIT = 10;
  localparam int STATE_FLAG_LSB = 12;

  // status codes, bit 1 = flag b, bit 0 = flag a; 1 = released
  localparam logic [1:0] CODE_OFF = 2'h3;
  localparam logic [1:0] CODE_CHARGING = 2'h2;
  localparam logic [1:0] CODE_FLOAT = 2'h0;
  localparam logic [1:0] CODE_FAULT = 2'h1;

  typedef enum logic [7:0] {
    ST_CHECK = 8'h01,
    ST_OFF = 8'h02,
    ST_PRE = 8'h04,
    ST_CC = 8'h08,
    ST_ABS = 8'h10,
    ST_FLOAT = 8'h20,
    ST_SUSP = 8'h40,
    ST_FAULT = 8'h80
  } csf_state_t;

endpackage : csf_pkg

// ===== hw/csf_sync_det.sv
// external sync clock detector: qualifies period and presence
// assumes sync_in already passed a two-flop synchroniser
`timescale 1ns/1ps
module csf_sync_det
#(
  parameter int PERIOD = csf_pkg::SW_PERIOD_CYC,
  parameter int CHECKS = csf_pkg::SYNC_CHECK_PERIODS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_in,
  input wire logic int_tick,
  output logic present,
  output logic ext_edge
);
  import csf_pkg::*;

  localparam int P_MIN = (PERIOD * (100 - SYNC_TOL_PCT)) / 100;
  localparam int P_MAX = (PERIOD * (100 + SYNC_TOL_PCT) + 99) / 100;
  localparam int CW = $clog2(2 * P_MAX + 2);

  logic sync_d;
  logic [CW-1:0] gap;
  logic [7:0] good_cnt;
  logic seen;

  wire rise = sync_in & ~sync_d;
  wire gap_ok = (gap >= CW'(P_MIN - 1)) && (gap <= CW'(P_MAX - 1));
  wire stale = gap >= CW'(2 * P_MAX);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_d <= 1'b0;
      gap <= '0;
      good_cnt <= 8'h00;
      seen <= 1'b0;
      present <= 1'b0;
      ext_edge <= 1'b0;
    end
    else
    begin
      sync_d <= sync_in;
      ext_edge <= rise;
      gap <= rise ? '0 : (stale ? gap : gap + CW'(1));
      if (rise && !gap_ok)
        good_cnt <= 8'h00;
      else if (stale)
        good_cnt <= 8'h00;
      else if (int_tick && seen && good_cnt != 8'(CHECKS))
        good_cnt <= good_cnt + 8'h01;
      // an internal period counts as checked only if a sync edge fell in it
      seen <= int_tick ? rise : (seen | rise);
      if (stale)
        present <= 1'b0;
      else if (good_cnt == 8'(CHECKS))
        present <= 1'b1;
    end
  end

endmodule : csf_sync_det

// ===== verification/csf_partner.sv
// far side: timer oscillator, optional sync clock, pulled-up flag pins
// assumes enables are driven by the bench just after rising edges
`timescale 1ns/1ps
module csf_partner
#(
  parameter int SYNC_PERIOD = 40
)
(
  input wire logic clk,
  input wire logic tick_en,
  input wire logic sync_en,
  input wire logic a_o,
  input wire logic a_oe,
  input wire logic b_o,
  input wire logic b_oe,
  output logic tick,
  output logic sync_clk,
  output wire logic flag_a,
  output wire logic flag_b
);
  int tc = 0;
  int sc = 0;
  // pull-ups: a released open-drain pin reads high
  assign flag_a = a_oe ? a_o : 1'h1;
  assign flag_b = b_oe ? b_o : 1'h1;
  initial tick = 1'h0;
  initial sync_clk = 1'h0;
  // sync stands low when absent; pulse width well above the minimum
  always_ff @(posedge clk)
  begin
    tc <= (tc == 19) ? 0 : tc + 1;
    sc <= (sc == SYNC_PERIOD - 1) ? 0 : sc + 1;
    tick <= tick_en && (tc < 10);
    sync_clk <= sync_en && (sc < 8);
  end
endmodule : csf_partner

// ===== verification/csf_supervisor_props.sv
// port-level checks of the charger supervisor
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
module csf_supervisor_props
#(
  parameter int TMR_FCHG = 64,
  parameter int SW_PERIOD = 142
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ,
  input wire logic PEAK_OVERCURRENT,
  input wire logic STATUS_FLAG_A_O,
  input wire logic STATUS_FLAG_A_OE,
  input wire logic STATUS_FLAG_B_O,
  input wire logic STATUS_FLAG_B_OE,
  input wire logic HIGH_SIDE_DRIVE,
  input wire logic EXT_CLOCK_ACTIVE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [15:0] low_cnt;
  logic [15:0] gap;
  logic [1:0] code_q;
  logic pend_lock;
  logic pend_loss;
  wire [1:0] code = {STATUS_FLAG_B_OE, STATUS_FLAG_A_OE};
  wire req = AVS_READ || AVS_WRITE;
  // counters saturate so long quiet stretches never wrap
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      low_cnt <= 16'h0000;
      gap <= 16'hFFFF;
      code_q <= 2'h0;
      pend_lock <= 1'h0;
      pend_loss <= 1'h0;
    end
    else
    begin
      low_cnt <= HIGH_SIDE_DRIVE ? 16'h0000 : low_cnt + {15'h0000, low_cnt != 16'hFFFF};
      gap <= (code != code_q) ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
      code_q <= code;
      pend_lock <= $rose(EXT_CLOCK_ACTIVE) | (pend_lock & ~$rose(HIGH_SIDE_DRIVE));
      pend_loss <= $fell(EXT_CLOCK_ACTIVE) | (pend_loss & ~$rose(HIGH_SIDE_DRIVE));
    end
  end
  AST_BUS_ANSWER: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered after one wait cycle");
  AST_BUS_IDLE: assert property (!req |=> AVS_WAITREQUEST)
    else $error("waitrequest low without a request");
  AST_BUS_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  AST_RESET_QUIET: assert property ($rose(RST_N) |-> AVS_WAITREQUEST && !IRQ && code == 2'h0 && !HIGH_SIDE_DRIVE)
    else $error("outputs not quiet after reset");
  AST_OPEN_DRAIN: assert property (!STATUS_FLAG_A_O && !STATUS_FLAG_B_O)
    else $error("flag output drives high");
  AST_FLAG_TICK: assert property ($changed(code) |-> gap >= SW_PERIOD - 1)
    else $error("flag code changed between switching ticks");
  AST_OVERCURRENT: assert property (PEAK_OVERCURRENT [*4] ##0 HIGH_SIDE_DRIVE |=> !HIGH_SIDE_DRIVE)
    else $error("high-side pulse continues during overcurrent");
  AST_HALT_NO_DRIVE: assert property (code == 2'h2 && !EXT_CLOCK_ACTIVE |-> !HIGH_SIDE_DRIVE)
    else $error("switching while fault or suspend shown");
  AST_LOCK_BLANK: assert property ($rose(HIGH_SIDE_DRIVE) && pend_lock |-> low_cnt >= 2 * SW_PERIOD - 2)
    else $error("lock blanking too short");
  AST_LOSS_BLANK: assert property ($rose(HIGH_SIDE_DRIVE) && pend_loss |-> low_cnt >= 10 * SW_PERIOD - 2)
    else $error("loss blanking too short");
  COV_LOCK: cover property ($rose(EXT_CLOCK_ACTIVE));
  COV_LOSS: cover property ($fell(EXT_CLOCK_ACTIVE));
  COV_FLOAT: cover property (code == 2'h3);
  COV_IRQ: cover property ($rose(IRQ));
endmodule : csf_supervisor_props

bind csf_supervisor csf_supervisor_props #(.TMR_FCHG(TMR_FCHG), .SW_PERIOD(SW_PERIOD)) csf_supervisor_props_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IRQ(IRQ), .PEAK_OVERCURRENT(PEAK_OVERCURRENT), .STATUS_FLAG_A_O(STATUS_FLAG_A_O),
  .STATUS_FLAG_A_OE(STATUS_FLAG_A_OE), .STATUS_FLAG_B_O(STATUS_FLAG_B_O), .STATUS_FLAG_B_OE(STATUS_FLAG_B_OE),
  .HIGH_SIDE_DRIVE(HIGH_SIDE_DRIVE), .EXT_CLOCK_ACTIVE(EXT_CLOCK_ACTIVE));

// ===== verification/tb_csf_supervisor.sv
// self-checking bench for the charger supervisor
// assumes csf_pkg, the design, the partner and the checker compiled first
`timescale 1ns/1ps
module tb_csf_supervisor;
  import csf_pkg::*;
  localparam int P = 40;
  localparam int TF = 64;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] t;
  logic [4:0] chk = 5'h00;
  logic [2:0] run = 3'h0;
  logic en = 1'h0, temp = 1'h0, ddok = 1'h0, cv = 1'h0, taper = 1'h0;
  logic oc = 1'h0, hot = 1'h0, cool = 1'h0, tick_en = 1'h0, sync_en = 1'h0;
  logic waitreq, irq, tick, sync_clk, a_o, a_oe, b_o, b_oe, drive, ext;
  wire flag_a;
  wire flag_b;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n1, n2;

  always #10 clock = ~clock;

  csf_supervisor #(.TMR_FCHG(TF), .SW_PERIOD(P)) csf_supervisor_i (
    .CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .IRQ(irq), .CHARGE_ENABLE(en),
    .FREQ_SET_SHORT(chk[0]), .GATE_SHORT(chk[1]), .TIMER_PIN_OPEN(chk[2]), .TIMER_PIN_SHORT(chk[3]),
    .REF_SHORT(chk[4]), .REF_OUT_OF_WINDOW(run[0]), .GATE_DRIVE_LOW(run[1]), .FEEDBACK_LOW(run[2]),
    .TEMP_OUT_OF_RANGE(temp), .DEEP_DISCHARGE_OK(ddok), .CV_REACHED(cv), .CURRENT_TAPERED(taper),
    .PEAK_OVERCURRENT(oc), .JUNCTION_HOT(hot), .JUNCTION_COOLED(cool), .CHARGE_TIMER_TICK(tick),
    .FREQ_SET_SYNC_PIN(sync_clk), .STATUS_FLAG_A_O(a_o), .STATUS_FLAG_A_OE(a_oe), .STATUS_FLAG_B_O(b_o),
    .STATUS_FLAG_B_OE(b_oe), .HIGH_SIDE_DRIVE(drive), .EXT_CLOCK_ACTIVE(ext));

  csf_partner #(.SYNC_PERIOD(P)) csf_partner_i (.clk(clock), .tick_en(tick_en), .sync_en(sync_en),
    .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .tick(tick), .sync_clk(sync_clk),
    .flag_a(flag_a), .flag_b(flag_b));

  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // one access; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clock);
    while (waitreq !== 1'h0 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clock);
    if (n == 20)
      check(32'h0000_0000, 32'h0000_0001);
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    check(q & m, e);
  endtask : rchk

  task automatic wait_state(input csf_state_t s);
    int n;
    n = 0;
    q = 32'h0000_0000;
    while (q[7:0] !== s && n < 400)
    begin
      bus(1'h0, ADDR_STATE, 32'h0000_0000);
      n++;
    end
    check(q & 32'h0000_00FF, 32'(s));
  endtask : wait_state

  // flags follow the state only at the next switching tick
  task automatic flags(input logic [1:0] e);
    repeat (P + 4) @(posedge clock);
    check({30'h0, flag_b, flag_a}, {30'h0, e});
    rchk(ADDR_STATE, 32'h0000_3000, {18'h0, e, 12'h000});
  endtask : flags

  task automatic till(input logic s, input logic v, output int n);
    n = 0;
    while (((s ? ext : drive) !== v) && n < 6000)
    begin
      @(posedge clock);
      n++;
    end
  endtask : till

  task automatic rst(input logic [4:0] c);
    chk <= c;
    {en, temp, ddok, cv, taper, oc, hot, cool, tick_en, sync_en, run} <= '0;
    rst_n <= 1'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
  endtask : rst

  task automatic t_regs;
    rchk(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
    rchk(ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    bus(1'h1, 8'h20, 32'hFFFF_FFFF);
    rchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    bus(1'h1, ADDR_TIMER, 32'h0000_FFFF);
    rchk(ADDR_TIMER, 32'hFFFF_FFFF, 32'h0000_0000);
    wait_state(ST_OFF);
    flags(2'h3);
  endtask : t_regs

  task automatic t_check;
    for (int i = 0; i < 5; i++)
    begin
      rst(5'h01 << i);
      wait_state(ST_FAULT);
    end
    flags(2'h1);
    rchk(ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    bus(1'h1, ADDR_IRQ_MASK, 32'h0000_003F);
    rchk(ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_003F);
    check({31'h0, irq}, 32'h0000_0001);
    bus(1'h1, ADDR_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0000_0000);
    chk <= 5'h00;
    en <= 1'h1;
    repeat (3 * P) @(posedge clock);
    rchk(ADDR_STATE, 32'h0000_00FF, 32'(ST_FAULT));
  endtask : t_check

  task automatic t_charge;
    rst(5'h00);
    en <= 1'h1;
    tick_en <= 1'h1;
    wait_state(ST_PRE);
    flags(2'h2);
    ddok <= 1'h1;
    wait_state(ST_CC);
    oc <= 1'h1;
    bus(1'h0, ADDR_TIMER, 32'h0000_0000);
    t = q;
    repeat (3 * P) @(posedge clock);
    oc <= 1'h0;
    rchk(ADDR_TIMER, 32'hFFFF_FFFF, t);
    cv <= 1'h1;
    wait_state(ST_ABS);
    temp <= 1'h1;
    wait_state(ST_SUSP);
    flags(2'h1);
    bus(1'h0, ADDR_TIMER, 32'h0000_0000);
    t = q;
    repeat (200) @(posedge clock);
    rchk(ADDR_TIMER, 32'hFFFF_FFFF, t);
    temp <= 1'h0;
    wait_state(ST_ABS);
    repeat (200) @(posedge clock);
    bus(1'h0, ADDR_TIMER, 32'h0000_0000);
    check(32'(q > t), 32'h0000_0001);
    taper <= 1'h1;
    wait_state(ST_FLOAT);
    flags(2'h0);
    rchk(ADDR_TIMER, 32'hFFFF_FFFF, 32'h0000_0000);
    run <= 3'h4;
    wait_state(ST_FAULT);
    run <= 3'h0;
    repeat (3 * P) @(posedge clock);
    rchk(ADDR_STATE, 32'h0000_00FF, 32'(ST_FAULT));
  endtask : t_charge

  task automatic t_run;
    for (int i = 0; i < 2; i++)
    begin
      rst(5'h00);
      en <= 1'h1;
      wait_state(ST_PRE);
      run <= 3'h1 << i;
      wait_state(ST_FAULT);
    end
    rst(5'h00);
    en <= 1'h1;
    tick_en <= 1'h1;
    wait_state(ST_PRE);
    wait_state(ST_FAULT);
  endtask : t_run

  task automatic t_sync;
    rst(5'h00);
    en <= 1'h1;
    ddok <= 1'h1;
    wait_state(ST_CC);
    till(1'h0, 1'h1, n1);
    till(1'h0, 1'h0, n1);
    till(1'h0, 1'h1, n2);
    check(n1 + n2, P);
    sync_en <= 1'h1;
    till(1'h1, 1'h1, n1);
    check(32'(n1 >= 112 * P && n1 < 6000), 32'h0000_0001);
    rchk(ADDR_STATE, 32'h0000_0200, 32'h0000_0200);
    sync_en <= 1'h0;
    till(1'h1, 1'h0, n1);
    check({31'h0, ext}, 32'h0000_0000);
    repeat (12 * P) @(posedge clock);
  endtask : t_sync

  task automatic t_hot;
    rst(5'h00);
    en <= 1'h1;
    wait_state(ST_PRE);
    hot <= 1'h1;
    wait_state(ST_OFF);
    rchk(ADDR_STATE, 32'h0000_0400, 32'h0000_0400);
    flags(2'h3);
    hot <= 1'h0;
    cool <= 1'h1;
    wait_state(ST_PRE);
  endtask : t_hot

  // bounds the run well above the slowest path, sync lock
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      finish_test();
    end
  end

  initial
  begin
    @(posedge clock);
    rst(5'h00);
    t_regs();
    t_check();
    t_charge();
    t_run();
    t_sync();
    t_hot();
    finish_test();
  end
endmodule : tb_csf_supervisor
